/* sdram_command_pin_decode.sv */
// Purpose: decodes controller pins into bank state, addresses and data gating
// Assumes: controller obeys command timing; precharge completes in one cycle
// Notes:   no storage array; location and data gating are presented as outputs
module sdram_command_pin_decode
#(
    parameter int NUM_BANKS = sdram_cmd_pkg::BANKS
)(
    input  wire logic                                 core_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 clkEn,
    input  wire logic                                 chipSel_n,
    input  wire logic                                 rowStrobe_n,
    input  wire logic                                 colStrobe_n,
    input  wire logic                                 writeEn_n,
    input  wire logic [sdram_cmd_pkg::BANK_W-1:0]     bankSelect,
    input  wire logic [sdram_cmd_pkg::ADDR_W-1:0]     addrBus,
    input  wire logic                                 lowerByteMask,
    input  wire logic                                 upperByteMask,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0]     dataLinesIn,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0]     readData,
    output logic      [sdram_cmd_pkg::DATA_W-1:0]     dataLinesOut,
    output logic      [sdram_cmd_pkg::DATA_W-1:0]     dataLinesOe,
    output logic      [sdram_cmd_pkg::DATA_W-1:0]     writeData,
    output logic      [sdram_cmd_pkg::DATA_W-1:0]     writeByteEn,
    output sdram_cmd_pkg::cmd_type                    lastCmd,
    output logic      [NUM_BANKS-1:0]                 bankActive,
    output logic      [sdram_cmd_pkg::ADDR_W-1:0]     modeWord,
    output logic      [sdram_cmd_pkg::WORD_ADR_W-1:0] wordAddr,
    output logic      [sdram_cmd_pkg::BANK_W-1:0]     accessBank,
    output logic                                      autoPrecharge,
    output logic                                      accessValid
);
    import sdram_cmd_pkg::*;

    // ==========================================================
    // command decode
    // refresh, burst stop and nop fall to CMD_OTHER and leave bank state and mode word unchanged
    function automatic cmd_type decodeCmd(input logic cs, input logic ras, input logic cas, input logic we);
        if (cs)
            return CMD_NONE;
        unique case ({ras, cas, we})
            3'h3:    return CMD_ACTIVATE;
            3'h2:    return CMD_PRECHARGE;
            3'h5:    return CMD_READ;
            3'h4:    return CMD_WRITE;
            3'h0:    return CMD_MODE;
            default: return CMD_OTHER;
        endcase
    endfunction

    cmd_type                 cmdNow;
    logic [ADDR_W-1:0]       rowAddr_reg [NUM_BANKS];
    logic [NUM_BANKS-1:0]    bankHit;
    logic [DATA_W-1:0]       byteMaskWide;

    assign cmdNow = decodeCmd(chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n);

    genvar gb;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++)
        begin : g_hit
            assign bankHit[gb] = (bankSelect == BANK_W'(gb));
        end
    endgenerate

    // lower mask covers bits 7:0, upper mask bits 15:8
    assign byteMaskWide = {{8{upperByteMask}}, {8{lowerByteMask}}};

    // ==========================================================
    // last command seen
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            lastCmd <= CMD_NONE;
        else if (clkEn)
            lastCmd <= cmdNow;
    end

    // ==========================================================
    // bank state and row capture
    generate
        for (gb = 0; gb < NUM_BANKS; gb++)
        begin : g_bank
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    bankActive[gb]  <= 1'b0;
                    rowAddr_reg[gb] <= '0;
                end
                else if (clkEn)
                begin
                    if (cmdNow == CMD_ACTIVATE && bankHit[gb])
                    begin
                        bankActive[gb]  <= 1'b1;
                        rowAddr_reg[gb] <= addrBus;
                    end
                    else if (cmdNow == CMD_PRECHARGE && (addrBus[AP_BIT] || bankHit[gb]))
                        bankActive[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // mode register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            modeWord <= MODE_RESET;
        else if (clkEn && cmdNow == CMD_MODE)
            modeWord <= addrBus;
    end

    // ==========================================================
    // column access: word location inside the addressed bank
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wordAddr      <= '0;
            accessBank    <= '0;
            autoPrecharge <= 1'b0;
            accessValid   <= 1'b0;
        end
        else if (clkEn)
        begin
            accessValid <= (cmdNow == CMD_READ || cmdNow == CMD_WRITE);
            if (cmdNow == CMD_READ || cmdNow == CMD_WRITE)
            begin
                wordAddr      <= {rowAddr_reg[bankSelect], addrBus[COL_W-1:0]};
                accessBank    <= bankSelect;
                autoPrecharge <= addrBus[AP_BIT];
            end
        end
    end

    // ==========================================================
    // data path; masks are sampled with the data, as on the pins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dataLinesOut <= '0;
            dataLinesOe  <= '0;
            writeData    <= '0;
            writeByteEn  <= '0;
        end
        else if (clkEn)
        begin
            dataLinesOut <= readData;
            dataLinesOe  <= (lastCmd == CMD_READ) ? ~byteMaskWide : '0;
            writeData    <= dataLinesIn;
            writeByteEn  <= (cmdNow == CMD_WRITE) ? ~byteMaskWide : '0;
        end
    end

    // ==========================================================
    // checks
    sequence seqActivate;
        clkEn && cmdNow == CMD_ACTIVATE && bankSelect == 2'h0;
    endsequence

    AST_ACT_OPENS: assert property (@(posedge core_clk) disable iff (!rst_n)
        seqActivate |=> bankActive[0]) else $error("activate did not open bank");
    AST_PRE_ALL: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_PRECHARGE && addrBus[AP_BIT] |=> bankActive == '0)
        else $error("precharge all left a bank open");
    AST_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && chipSel_n |=> lastCmd == CMD_NONE && $stable(bankActive) && $stable(modeWord))
        else $error("deselected command acted");
    AST_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_MODE |=> modeWord == $past(addrBus)) else $error("mode word wrong");
    AST_COL: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_READ |=> accessValid && wordAddr[COL_W-1:0] == $past(addrBus[COL_W-1:0])
        && autoPrecharge == $past(addrBus[AP_BIT])) else $error("column capture wrong");
    AST_ROW: assert property (@(posedge core_clk) disable iff (!rst_n)
        seqActivate ##1 (clkEn && cmdNow == CMD_WRITE && bankSelect == 2'h0)
        |=> wordAddr[WORD_ADR_W-1:COL_W] == $past(addrBus, 2)) else $error("row not used");
    AST_WMASK: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_WRITE && lowerByteMask |=> writeByteEn[7:0] == 8'h00)
        else $error("masked byte written");
    AST_RMASK: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && lastCmd == CMD_READ && !upperByteMask |=> dataLinesOe[15:8] == 8'hff)
        else $error("upper byte not driven");

    // ==========================================================
    // checks: column access flag and write column capture
    sequence seqColAccess;
        clkEn && (cmdNow == CMD_READ || cmdNow == CMD_WRITE);
    endsequence

    sequence seqNoColAccess;
        clkEn && !(cmdNow == CMD_READ || cmdNow == CMD_WRITE);
    endsequence

    AST_VALID_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        seqColAccess |=> accessValid && accessBank == $past(bankSelect))
        else $error("column access not flagged");
    AST_VALID_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        seqNoColAccess |=> !accessValid) else $error("access flag outlived its command");
    AST_WR_AP: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_WRITE |=> autoPrecharge == $past(addrBus[AP_BIT])
        && wordAddr[COL_W-1:0] == $past(addrBus[COL_W-1:0])) else $error("write column capture wrong");

    // ==========================================================
    // checks: precharge, unsupported commands, idle outputs, freeze
    AST_PRE_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_PRECHARGE && !addrBus[AP_BIT] && bankSelect == 2'h1
        |=> !bankActive[1] && bankActive[0] == $past(bankActive[0])) else $error("precharge hit wrong bank");
    AST_OTHER: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow == CMD_OTHER |=> $stable(bankActive) && $stable(modeWord) && !accessValid)
        else $error("unsupported command acted");
    // idle enables read zero so a stray enable cannot reach storage or the pins
    AST_WBE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && cmdNow != CMD_WRITE |=> writeByteEn == '0) else $error("write enable without write");
    AST_OE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && lastCmd != CMD_READ |=> dataLinesOe == '0) else $error("driving without read");
    // a frozen edge must not half-advance the pipeline, or outputs fall out of step
    AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clkEn |=> $stable(lastCmd) && $stable(bankActive) && $stable(modeWord) && $stable(wordAddr))
        else $error("state moved while clock enable low");
endmodule // sdram_command_pin_decode

/* sdram_cmd_pkg.sv */
// Purpose: constants for the sdram command and address pin decoder
// Assumes: single clock, synchronous active-low reset
// Notes:   all pins sampled on the rising edge of core_clk
//
// Functional notes
// - activation captures all twelve address lines as row of selected bank
// - column access takes column from lines 0..8, line 10 selects auto-precharge
// - row plus column picks one of two million words in the bank
// - precharge samples line 10: high means all banks, low means selected bank
// - mode register load takes the op-code from the address lines
// - decoder acts only while chip select sampled low, else commands ignored
// - strobes latched each rising edge, command decoded with chip select
// - cs/row low, column/write high: activate, bank becomes active
// - cs/row low, column high, write low: precharge, bank returns idle
// - cs low, row high, column low: column access starts
// - byte masks disable read drivers and block masked write bytes
// - sixteen data lines move on rising clock edges both directions
// - two bank select inputs choose one of four banks
// - column access: write-enable high reads, low writes
package sdram_cmd_pkg;
    localparam int ADDR_W     = 12;
    localparam int COL_W      = 9;
    localparam int BANK_W     = 2;
    localparam int DATA_W     = 16;
    localparam int AP_BIT     = 10;
    localparam int BANKS      = 4;
    localparam int WORD_ADR_W = 21;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_ACTIVATE, CMD_PRECHARGE, CMD_READ, CMD_WRITE, CMD_MODE, CMD_OTHER
    } cmd_type;

    typedef enum logic {BANK_IDLE, BANK_ACTIVE} bank_state_type;

    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
endpackage

/* sdram_ctrl_model.sv */
// Purpose: controller side of the sdram pins, issuing one command per issue call, two per issueTwo call
// Assumes: pins change only by non-blocking assignment at the rising edge
// Notes:   no command timing is modelled; the bench picks the order
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
(
    input  wire logic                             core_clk,
    output logic                                  clkEn,
    output logic                                  chipSel_n,
    output logic                                  rowStrobe_n,
    output logic                                  colStrobe_n,
    output logic                                  writeEn_n,
    output logic [sdram_cmd_pkg::BANK_W-1:0]      bankSelect,
    output logic [sdram_cmd_pkg::ADDR_W-1:0]      addrBus,
    output logic                                  lowerByteMask,
    output logic                                  upperByteMask,
    output logic                                  wrDrive,
    output logic [sdram_cmd_pkg::DATA_W-1:0]      wrData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // pin driver
    initial
    begin
        {clkEn, chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, wrDrive} = 6'h1e;
        {bankSelect, addrBus, lowerByteMask, upperByteMask, wrData} = 32'h0;
    end
    // c is {cs, row, col, we}; returns just after the edge that takes the command
    task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a,
                         input logic ena, input logic [15:0] wd, input logic drv, input logic [1:0] msk);
        @(posedge core_clk);
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, bankSelect, addrBus, clkEn} <= {c, ba, a, ena};
        {wrDrive, wrData, upperByteMask, lowerByteMask} <= {drv, wd, msk};
        @(posedge core_clk);
        // released lines show the inverse and the data bus the moving pattern,
        // so a stale value cannot pass for a new one
        {chipSel_n, clkEn, wrDrive, bankSelect, addrBus} <= {3'h6, ~ba, ~a};
        #1;
    endtask
    // two commands on consecutive edges to one bank, masks open, data bus undriven
    task automatic issueTwo(input logic [3:0] c0, input logic [11:0] a0, input logic [3:0] c1,
                            input logic [11:0] a1, input logic [1:0] ba);
        @(posedge core_clk);
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, bankSelect, addrBus, clkEn} <= {c0, ba, a0, 1'b1};
        {wrDrive, upperByteMask, lowerByteMask} <= 3'h0;
        @(posedge core_clk);
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, addrBus} <= {c1, a1};
        @(posedge core_clk);
        {chipSel_n, bankSelect, addrBus} <= {1'b1, ~ba, ~a1};
        #1;
    endtask
endmodule // sdram_ctrl_model

/* tb.sv */
// Purpose: self-checking bench for the sdram command pin decoder
// Assumes: sdram_ctrl_model drives every command pin
// Notes:   data lines resolved here from both drive enables
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_cmd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] readData = 16'hc3a5;
    int nMismatch = 0;
    int compares = 0;
    int cyc = 0;
    logic clkEn, chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, lowerByteMask, upperByteMask, wrDrive;
    logic [1:0] bankSelect, accessBank;
    logic [11:0] addrBus, modeWord;
    logic [15:0] wrData, dq, dataLinesOut, dataLinesOe, writeData, writeByteEn;
    logic [3:0] bankActive;
    logic [20:0] wordAddr;
    logic autoPrecharge, accessValid;
    cmd_type lastCmd;
    // ==========================================
    // clock, wire resolution, instances
    always #5 core_clk = ~core_clk;
    // undriven lines carry a pattern that moves every cycle
    assign dq = (dataLinesOe & dataLinesOut) | (~dataLinesOe & (wrDrive ? wrData : ~cyc[15:0]));
    sdram_ctrl_model sdram_ctrl_model_inst (.core_clk, .clkEn, .chipSel_n, .rowStrobe_n, .colStrobe_n,
        .writeEn_n, .bankSelect, .addrBus, .lowerByteMask, .upperByteMask, .wrDrive, .wrData);
    sdram_command_pin_decode sdram_command_pin_decode_inst (.core_clk, .rst_n, .clkEn, .chipSel_n,
        .rowStrobe_n, .colStrobe_n, .writeEn_n, .bankSelect, .addrBus, .lowerByteMask, .upperByteMask,
        .dataLinesIn(dq), .readData, .dataLinesOut, .dataLinesOe, .writeData, .writeByteEn, .lastCmd,
        .bankActive, .modeWord, .wordAddr, .accessBank, .autoPrecharge, .accessValid);
    // ==========================================
    // checking
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            nMismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic testDone;
        if (nMismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // run is about fifty cycles; the ceiling of 2000 leaves wide margin
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            nMismatch++;
            testDone;
        end
    end
    // ==========================================
    // scenarios
    task automatic tActivate;
        for (int b = 0; b < 4; b++)
        begin
            sdram_ctrl_model_inst.issue(4'h3, 2'(b), 12'ha5a ^ 12'(b), 1'b1, 16'h0, 1'b0, 2'h0);
            chk(32'(bankActive), 32'((1 << (b + 1)) - 1));
        end
        chk(32'(lastCmd), 32'(CMD_ACTIVATE));
    endtask
    task automatic tWrite;
        sdram_ctrl_model_inst.issue(4'h4, 2'h2, 12'h5ff, 1'b1, 16'h1234, 1'b1, 2'h1);
        chk({11'h0, wordAddr}, {11'h0, 12'ha58, 9'h1ff});
        chk({29'h0, accessBank, autoPrecharge}, 32'h5);
        chk({31'h0, accessValid}, 32'h1);
        chk(32'(lastCmd), 32'(CMD_WRITE));
        chk({writeByteEn, writeData}, 32'hff001234);
        @(posedge core_clk);
        #1;
        chk({31'h0, accessValid}, 32'h0);
    endtask
    task automatic tRead;
        sdram_ctrl_model_inst.issue(4'h5, 2'h1, 12'h0a3, 1'b1, 16'h0, 1'b0, 2'h2);
        chk(32'(lastCmd), 32'(CMD_READ));
        chk({8'h0, accessBank, autoPrecharge, wordAddr}, {8'h0, 3'h2, 12'ha5b, 9'h0a3});
        @(posedge core_clk);
        #1;
        chk({dataLinesOe, dataLinesOut & 16'h00ff}, 32'h00ff00a5);
    endtask
    task automatic tIgnoreAndPrecharge;
        sdram_ctrl_model_inst.issue(4'ha, 2'h0, 12'h400, 1'b1, 16'h0, 1'b0, 2'h0);
        chk({28'h0, bankActive}, 32'hf);
        chk(32'(lastCmd), 32'(CMD_NONE));
        sdram_ctrl_model_inst.issue(4'h2, 2'h0, 12'h400, 1'b0, 16'h0, 1'b0, 2'h0);
        chk({28'h0, bankActive}, 32'hf);
        sdram_ctrl_model_inst.issue(4'h2, 2'h1, 12'hbff, 1'b1, 16'h0, 1'b0, 2'h0);
        chk({28'h0, bankActive}, 32'hd);
        chk(32'(lastCmd), 32'(CMD_PRECHARGE));
        sdram_ctrl_model_inst.issue(4'h2, 2'h0, 12'h400, 1'b1, 16'h0, 1'b0, 2'h0);
        chk({28'h0, bankActive}, 32'h0);
    endtask
    task automatic tMode;
        sdram_ctrl_model_inst.issue(4'h0, 2'h0, 12'h037, 1'b1, 16'h0, 1'b0, 2'h0);
        chk({20'h0, modeWord}, 32'h037);
        chk(32'(lastCmd), 32'(CMD_MODE));
        // a refresh must not be taken for a mode load
        sdram_ctrl_model_inst.issue(4'h1, 2'h0, 12'hfff, 1'b1, 16'h0, 1'b0, 2'h0);
        chk({20'h0, modeWord}, 32'h037);
        chk(32'(lastCmd), 32'(CMD_OTHER));
    endtask
    task automatic tBackToBack;
        sdram_ctrl_model_inst.issueTwo(4'h3, 12'h3c6, 4'h4, 12'h0f0, 2'h0);
        chk({11'h0, wordAddr}, {11'h0, 12'h3c6, 9'h0f0});
        chk({12'h0, writeByteEn, bankActive}, 32'hffff1);
        chk({28'h0, accessBank, autoPrecharge, accessValid}, 32'h1);
        sdram_ctrl_model_inst.issueTwo(4'h3, 12'h7e1, 4'h5, 12'h405, 2'h3);
        chk({8'h0, accessBank, autoPrecharge, wordAddr}, {8'h0, 3'h7, 12'h7e1, 9'h005});
        chk(32'(lastCmd), 32'(CMD_READ));
        @(posedge core_clk);
        #1;
        chk({dataLinesOe, dataLinesOut}, 32'hffffc3a5);
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk({20'h0, modeWord}, 32'(MODE_RESET));
        tActivate();
        tWrite();
        tRead();
        tIgnoreAndPrecharge();
        tMode();
        tBackToBack();
        testDone();
    end
endmodule // tb
